// ===== sipl_host.sv
// Host model driving the shift clock and serial data
`timescale 1ns/10ps
`default_nettype none
module sipl_host (
  output logic shift_clk_o,
  output logic serial_in_o
);
  initial begin
    shift_clk_o = 1'b0;
    serial_in_o = 1'b0;
  end
  // Clock only runs inside a frame; msb goes out first
  task automatic send(input logic [7:0] d, input int n, input int gap);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_o = d[i];
      #24 shift_clk_o = 1'b1;
      #24 shift_clk_o = 1'b0;
      #(gap);
    end
    // Released line flips so a stale level never looks valid
    serial_in_o = ~serial_in_o;
  endtask : send
endmodule : sipl_host
`default_nettype wire

// ===== sipl_pkg.sv
// Constants shared by the serial-in, parallel-out latch block
package sipl_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PTR_W = 4;
  localparam logic BIT_RST = 1'h0;
  localparam logic [3:0] PTR_RST = 4'h0;
endpackage : sipl_pkg

// ===== sipl_shift_latch.sv
// Serial-in shift register with parallel storage register and output enable
`timescale 1ns/10ps
`default_nettype none

// Function
// - An 8-bit serial-in shift register feeds an 8-bit storage register that drives the parallel outputs.
// - Shift and storage registers each have their own clock; apart from the shift clear, they change only on its rising edge.
// - Each rising shift clock edge with clear high moves every stage up by one and loads serial_in into stage 0.
// - A low shift_clear_n clears the shift register at once, overrides shifting and forces cascade_out to 0.
// - Each rising latch_clock edge copies the shift register contents into the storage register.
// - A high output_enable_n floats all parallel outputs; a low one lets them drive the storage contents.
// - The last shift stage is presented on cascade_out for chaining.
// - With both clocks tied together the storage register takes the pre-shift state, one pulse behind.
module sipl_shift_latch #(
  parameter int unsigned DATA_W = sipl_pkg::DATA_W,
  parameter int unsigned PTR_W = sipl_pkg::PTR_W
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic shift_clk_i,
  input wire logic serial_in_i,
  input wire logic shift_clear_n_i,
  input wire logic latch_clock_i,
  input wire logic output_enable_n_i,
  output logic [DATA_W-1:0] parallel_out_o,
  output logic [DATA_W-1:0] parallel_oe_o,
  output logic cascade_out_o
);

  localparam int unsigned DEPTH = 1 << PTR_W;

  // Link domain
  logic [DATA_W-1:0] shift_ff;
  logic [PTR_W-1:0] wr_bin_ff;
  logic [PTR_W-1:0] nxt_wr_bin;
  logic [PTR_W-1:0] wr_gray_ff;
  logic ring_ff [DEPTH];
  logic shift_rst_n;

  // Core domain
  logic [PTR_W-1:0] wr_gray_s1_ff;
  logic [PTR_W-1:0] wr_gray_s2_ff;
  logic [PTR_W-1:0] wr_bin_sync;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [DATA_W-1:0] mirror_ff;
  logic [DATA_W-1:0] storage_ff;
  logic latch_s1_ff;
  logic latch_s2_ff;
  logic latch_s3_ff;
  logic clr_s1_ff;
  logic clr_s2_ff;
  logic oe_s1_ff;
  logic oe_s2_ff;
  logic latch_evt;
  logic apply_bit;

  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = g;
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray2bin

  // Clear acts without a clock edge
  assign shift_rst_n = resetn_i & shift_clear_n_i;

  always_ff @(posedge shift_clk_i or negedge shift_rst_n) begin
    if (!shift_rst_n) begin
      shift_ff <= {DATA_W{sipl_pkg::BIT_RST}};
    end else begin
      shift_ff <= {shift_ff[DATA_W-2:0], serial_in_i};
    end
  end

  assign cascade_out_o = shift_ff[DATA_W-1];

  // Each shifted bit is logged so the core side can replay it in order
  assign nxt_wr_bin = wr_bin_ff + 1'b1;

  always_ff @(posedge shift_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_bin_ff <= sipl_pkg::PTR_RST;
      wr_gray_ff <= sipl_pkg::PTR_RST;
    end else if (shift_clear_n_i) begin
      wr_bin_ff <= nxt_wr_bin;
      wr_gray_ff <= nxt_wr_bin ^ (nxt_wr_bin >> 1);
    end
  end

  always_ff @(posedge shift_clk_i) begin
    if (shift_clear_n_i) begin
      ring_ff[wr_bin_ff] <= serial_in_i;
    end
  end

  // Synchronisers
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_gray_s1_ff <= sipl_pkg::PTR_RST;
      wr_gray_s2_ff <= sipl_pkg::PTR_RST;
    end else begin
      wr_gray_s1_ff <= wr_gray_ff;
      wr_gray_s2_ff <= wr_gray_s1_ff;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latch_s1_ff <= sipl_pkg::BIT_RST;
      latch_s2_ff <= sipl_pkg::BIT_RST;
      latch_s3_ff <= sipl_pkg::BIT_RST;
      clr_s1_ff <= sipl_pkg::BIT_RST;
      clr_s2_ff <= sipl_pkg::BIT_RST;
      oe_s1_ff <= ~sipl_pkg::BIT_RST;
      oe_s2_ff <= ~sipl_pkg::BIT_RST;
    end else begin
      latch_s1_ff <= latch_clock_i;
      latch_s2_ff <= latch_s1_ff;
      latch_s3_ff <= latch_s2_ff;
      clr_s1_ff <= shift_clear_n_i;
      clr_s2_ff <= clr_s1_ff;
      oe_s1_ff <= output_enable_n_i;
      oe_s2_ff <= oe_s1_ff;
    end
  end

  assign wr_bin_sync = gray2bin(wr_gray_s2_ff);
  assign latch_evt = latch_s2_ff & ~latch_s3_ff;
  assign apply_bit = (rd_ptr_ff != wr_bin_sync);

  // Mirror of the shift register, replayed one logged bit per cycle
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mirror_ff <= {DATA_W{sipl_pkg::BIT_RST}};
      rd_ptr_ff <= sipl_pkg::PTR_RST;
    end else if (!clr_s2_ff) begin
      mirror_ff <= {DATA_W{sipl_pkg::BIT_RST}};
      rd_ptr_ff <= wr_bin_sync;
    end else if (apply_bit) begin
      mirror_ff <= {mirror_ff[DATA_W-2:0], ring_ff[rd_ptr_ff]};
      rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end

  // Storage takes the mirror as it stood before this cycle's replay
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      storage_ff <= {DATA_W{sipl_pkg::BIT_RST}};
    end else if (latch_evt) begin
      storage_ff <= mirror_ff;
    end
  end

  assign parallel_out_o = storage_ff;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      parallel_oe_o <= {DATA_W{sipl_pkg::BIT_RST}};
    end else begin
      parallel_oe_o <= {DATA_W{~oe_s2_ff}};
    end
  end

  AST_SHIFT_STEP: assert property (
    @(posedge shift_clk_i) disable iff (!resetn_i || !shift_clear_n_i)
    1 |=> shift_ff == {$past(shift_ff[DATA_W-2:0]), $past(serial_in_i)})
    else $error("shift stage did not follow its predecessor");

  AST_CASCADE: assert property (
    @(posedge shift_clk_i) disable iff (!resetn_i || !shift_clear_n_i)
    1 |=> cascade_out_o == $past(shift_ff[DATA_W-2]))
    else $error("cascade output not last stage");

  AST_CLEAR: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    !shift_clear_n_i |-> (cascade_out_o == 1'b0 && shift_ff == '0))
    else $error("clear did not empty shift register");

  AST_MIRROR_CLR: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    !clr_s2_ff |=> mirror_ff == '0)
    else $error("mirror not cleared");

  AST_LATCH: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    latch_evt |=> parallel_out_o == $past(mirror_ff))
    else $error("latch edge did not copy shift contents");

  AST_HOLD: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    !latch_evt |=> $stable(parallel_out_o))
    else $error("storage changed without latch edge");

  AST_LAG: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    (latch_evt && apply_bit) |=> parallel_out_o != mirror_ff ||
      $past(mirror_ff) == mirror_ff)
    else $error("storage took the post-shift state");

  AST_OE: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    output_enable_n_i |-> ##3 parallel_oe_o == '0)
    else $error("outputs not floated");

  // Link-side checks
  AST_CASCADE_TOP: assert property (
    @(posedge shift_clk_i) disable iff (!resetn_i)
    1 |-> cascade_out_o == shift_ff[DATA_W-1])
    else $error("cascade output detached from last stage");

  AST_SHIFT_CLR_HOLD: assert property (
    @(posedge shift_clk_i) disable iff (!resetn_i)
    !shift_clear_n_i |-> shift_ff == '0)
    else $error("shift edge moved data while cleared");

  AST_CASCADE_CLR: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    !shift_rst_n |-> cascade_out_o == 1'b0)
    else $error("cascade output high during clear");

  AST_WR_HOLD: assert property (
    @(posedge shift_clk_i) disable iff (!resetn_i)
    !shift_clear_n_i |=> $stable(wr_bin_ff))
    else $error("bit logged while cleared");

  AST_WR_STEP: assert property (
    @(posedge shift_clk_i) disable iff (!resetn_i)
    shift_clear_n_i |=> wr_bin_ff == $past(wr_bin_ff) + 1'b1)
    else $error("shift edge not logged");

  AST_GRAY_ONEHOT: assert property (
    @(posedge shift_clk_i) disable iff (!resetn_i)
    1 |=> $onehot0(wr_gray_ff ^ $past(wr_gray_ff)))
    else $error("write pointer moved more than one bit");

  AST_GRAY_MATCH: assert property (
    @(posedge shift_clk_i) disable iff (!resetn_i)
    1 |-> wr_gray_ff == (wr_bin_ff ^ (wr_bin_ff >> 1)))
    else $error("gray pointer out of step with count");

  // Core-side checks
  AST_SYNC_GRAY_STEP: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    1 |-> $onehot0(wr_gray_s2_ff ^ $past(wr_gray_s2_ff)))
    else $error("synchronised pointer jumped");

  AST_LATCH_PULSE: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    latch_evt |=> !latch_evt)
    else $error("latch event longer than one cycle");

  AST_LATCH_SRC: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    latch_evt |-> $rose(latch_s2_ff))
    else $error("latch event without rising latch clock");

  AST_MIRROR_HOLD: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    (clr_s2_ff && !apply_bit) |=> $stable(mirror_ff))
    else $error("mirror moved without a logged bit");

  AST_MIRROR_STEP: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    (clr_s2_ff && apply_bit) |=>
      mirror_ff[DATA_W-1:1] == $past(mirror_ff[DATA_W-2:0]))
    else $error("mirror did not shift up by one");

  AST_MIRROR_BIT0: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    (clr_s2_ff && apply_bit) |=> mirror_ff[0] == $past(ring_ff[rd_ptr_ff]))
    else $error("mirror stage 0 not the logged bit");

  AST_RD_STEP: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    (clr_s2_ff && apply_bit) |=> rd_ptr_ff == $past(rd_ptr_ff) + 1'b1)
    else $error("replay pointer did not advance");

  AST_RD_CLR: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    !clr_s2_ff |=> rd_ptr_ff == $past(wr_bin_sync))
    else $error("clear did not drop pending bits");

  AST_STORE_CLR_KEEP: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    (!shift_clear_n_i && !latch_evt) |=> $stable(parallel_out_o))
    else $error("clear disturbed the storage register");

  // Output enable checks
  AST_OE_ON: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    !output_enable_n_i |-> ##3 parallel_oe_o == '1)
    else $error("outputs not driven");

  AST_OE_UNIFORM: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    1 |-> (parallel_oe_o == '0 || parallel_oe_o == '1))
    else $error("output enables disagree");

  AST_OE_FOLLOW: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    1 |=> parallel_oe_o == {DATA_W{~$past(oe_s2_ff)}})
    else $error("output enable not following its pin");

endmodule : sipl_shift_latch

`default_nettype wire

// ===== tb_sipl_shift_latch.sv
// Self-checking bench for the shift and storage register block
`timescale 1ns/10ps
`default_nettype none
module tb_sipl_shift_latch;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic shift_clear_n_i = 1'b0;
  logic latch_clock_i = 1'b0;
  logic output_enable_n_i = 1'b1;
  wire logic shift_clk;
  wire logic serial_in;
  logic [7:0] pout;
  logic [7:0] poe;
  logic casc;
  logic [7:0] m_sr = 8'h00;
  logic [7:0] d;
  int fail_count = 0;
  int total_checks = 0;
  always #10 core_clk_i = ~core_clk_i;
  sipl_host host (.shift_clk_o(shift_clk), .serial_in_o(serial_in));
  sipl_shift_latch dut (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .shift_clk_i(shift_clk),
    .serial_in_i(serial_in),
    .shift_clear_n_i(shift_clear_n_i),
    .latch_clock_i(latch_clock_i),
    .output_enable_n_i(output_enable_n_i),
    .parallel_out_o(pout),
    .parallel_oe_o(poe),
    .cascade_out_o(casc)
  );
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : cyc
  // Mirror needs a few core cycles before a latch can see it
  task automatic shift(input logic [7:0] v, input int n);
    host.send(v, n, $urandom_range(0, 30));
    for (int i = n - 1; i >= 0; i--) begin
      if (shift_clear_n_i) m_sr = {m_sr[6:0], v[i]};
    end
    cyc(6);
  endtask : shift
  task automatic latch;
    latch_clock_i = 1'b1;
    cyc(4);
    latch_clock_i = 1'b0;
    cyc(4);
  endtask : latch
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  initial begin
    #400000;
    fail_count++;
    results;
  end
  initial begin
    void'($urandom(32'hd155));
    cyc(10);
    resetn_i = 1'b1;
    shift_clear_n_i = 1'b1;
    cyc(4);
    output_enable_n_i = 1'b0;
    cyc(4);
    check(poe, 8'hff);
    d = 8'($urandom);
    shift(d, 8);
    latch;
    check(pout, d);
    for (int k = 0; k < 6; k++) begin
      d = pout;
      shift(8'($urandom), $urandom_range(1, 8));
      check({7'h00, casc}, {7'h00, m_sr[7]});
      check(pout, d);
      latch;
      check(pout, m_sr);
    end
    d = pout;
    shift_clear_n_i = 1'b0;
    cyc(2);
    m_sr = 8'h00;
    check({7'h00, casc}, 8'h00);
    shift(8'hff, 8);
    check({7'h00, casc}, 8'h00);
    check(pout, d);
    shift_clear_n_i = 1'b1;
    cyc(2);
    latch;
    check(pout, m_sr);
    output_enable_n_i = 1'b1;
    cyc(4);
    check(poe, 8'h00);
    results;
  end
endmodule : tb_sipl_shift_latch
`default_nettype wire
